/* src/bregsq_consts.svh */
`ifndef BREGSQ_CONSTS_SVH
`define BREGSQ_CONSTS_SVH

// Register bus layout
`define BREGSQ_ADDR_W          4
`define BREGSQ_OFF_CTRL        4'h0
`define BREGSQ_OFF_STATUS      4'h4
`define BREGSQ_OFF_REF         4'h8
`define BREGSQ_OFF_HICCUP      4'hC
`define BREGSQ_RESP_OKAY       2'h0
`define BREGSQ_RESP_SLVERR     2'h2

// Control register fields
`define BREGSQ_CTRL_SWEN_BIT   0
`define BREGSQ_CTRL_CLR_BIT    1
`define BREGSQ_CTRL_SWEN_RST   1'b1

// Status register fields
`define BREGSQ_ST_STATE_LSB    0
`define BREGSQ_ST_FBMODE_BIT   5
`define BREGSQ_ST_INPUT_UNDERVOLTAGE_LOCKOUT_BIT     6
`define BREGSQ_ST_HOT_BIT      7
`define BREGSQ_ST_OC_BIT       8
`define BREGSQ_ST_EN_BIT       9

// Reference field positions
`define BREGSQ_REF_CUR_LSB     0
`define BREGSQ_REF_TGT_LSB     16

// Voltage select codes and reference targets in millivolts
`define BREGSQ_VSEL_EXT        3'h7
`define BREGSQ_MV_SEL0         12'hCE4
`define BREGSQ_MV_SEL1         12'h9C4
`define BREGSQ_MV_SEL2         12'h708
`define BREGSQ_MV_SEL3         12'h5DC
`define BREGSQ_MV_SEL4         12'h4E2
`define BREGSQ_MV_SEL5         12'h4B0
`define BREGSQ_MV_SEL6         12'h320
`define BREGSQ_MV_FB           12'h25B

// Timing
`define BREGSQ_CLK_MHZ         40
`define BREGSQ_SLEW_UV_PER_US  1650
`define BREGSQ_SS_RISE_US      1100
`define BREGSQ_OCP_HOLD_US     1000
`define BREGSQ_SLEW_CYC        ((`BREGSQ_CLK_MHZ * 1000) / `BREGSQ_SLEW_UV_PER_US)
`define BREGSQ_FB_STEP_CYC     ((`BREGSQ_SS_RISE_US * `BREGSQ_CLK_MHZ) / `BREGSQ_MV_FB)
`define BREGSQ_OCP_HOLD_CYC    (`BREGSQ_OCP_HOLD_US * `BREGSQ_CLK_MHZ)

// Pin synchroniser width
`define BREGSQ_NPINS           9

`endif

/* src/bregsq_pkg.sv */
package bregsq_pkg;

   typedef logic [11:0] bregsq_mv_t;

   typedef enum logic [4:0] {
      ST_OFF   = 5'h01,
      ST_SOFT  = 5'h02,
      ST_RUN   = 5'h04,
      ST_OCP   = 5'h08,
      ST_THERM = 5'h10
   } bregsq_state_t;

endpackage

/* src/bregsq_ramp_if.sv */
`timescale 1ns/1ps
interface bregsq_ramp_if;
   import bregsq_pkg::*;
   logic       hold_zero;
   logic       step_en;
   logic       fb_mode;
   bregsq_mv_t target;
   bregsq_mv_t ref_mv;
   logic       at_target;

   modport ctrl (output hold_zero, step_en, fb_mode, target, input ref_mv, at_target);
   modport ramp (input hold_zero, step_en, fb_mode, target, output ref_mv, at_target);
endinterface

/* src/bregsq_ramp.sv */
`timescale 1ns/1ps
`include "bregsq_consts.svh"
module bregsq_ramp
   import bregsq_pkg::*;
(
   // Clock and reset
   input wire logic    aclk,
   input wire logic    aresetn,
   // Control side
   bregsq_ramp_if.ramp rif
);

   logic [6:0] cnt_ff;
   logic [6:0] nxt_cnt;
   bregsq_mv_t ref_ff;
   bregsq_mv_t nxt_ref;
   wire  [6:0] interval_last;
   wire        step_now;
   wire        go_up;

   assign interval_last = rif.fb_mode ? 7'(`BREGSQ_FB_STEP_CYC - 1)
                                      : 7'(`BREGSQ_SLEW_CYC - 1);
   assign step_now      = rif.step_en & ~rif.at_target & (cnt_ff == interval_last);
   assign go_up         = rif.target > ref_ff;
   assign rif.ref_mv    = ref_ff;
   assign rif.at_target = (ref_ff == rif.target);

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_ref = ref_ff;
      if (rif.hold_zero) begin
         nxt_cnt = 7'h00;
         nxt_ref = 12'h000;
      end else if (rif.step_en && !rif.at_target) begin
         nxt_cnt = step_now ? 7'h00 : 7'(cnt_ff + 7'h01);
         if (step_now) begin
            nxt_ref = go_up ? 12'(ref_ff + 12'h001) : 12'(ref_ff - 12'h001);
         end
      end else begin
         nxt_cnt = 7'h00;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 7'h00;
         ref_ff <= 12'h000;
      end else begin
         cnt_ff <= nxt_cnt;
         ref_ff <= nxt_ref;
      end
   end

endmodule

/* src/bregsq_top.sv */
`timescale 1ns/1ps
`include "bregsq_consts.svh"
module bregsq_top
   import bregsq_pkg::*;
#(
   parameter int unsigned OCP_HOLD_CYC = `BREGSQ_OCP_HOLD_CYC
) (
   // Clock and reset
   input  wire logic                      aclk,
   input  wire logic                      aresetn,
   // Pins and analog comparators
   input  wire logic [2:0]                voltage_select_bits,
   input  wire logic                      enable_pin,
   input  wire logic                      input_undervoltage_lockout_above_rise,
   input  wire logic                      input_undervoltage_lockout_above_fall,
   input  wire logic                      overcurrent_detect,
   input  wire logic                      thermal_hot,
   input  wire logic                      thermal_cooled,
   // Power stage controls
   output logic [11:0]                    ref_mv,
   output logic                           fb_select,
   output logic                           high_side_en,
   output logic                           low_side_force,
   output logic                           switching_en,
   output logic                           shutdown_low_power,
   // AXI4-Lite write
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [`BREGSQ_ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   output logic [1:0]                     s_axi_bresp,
   // AXI4-Lite read
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   input  wire logic [`BREGSQ_ADDR_W-1:0] s_axi_araddr,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp
);

   // Pin synchronisers: three stages, accept when stages two and three agree
   wire  [`BREGSQ_NPINS-1:0] pins_raw;
   logic [`BREGSQ_NPINS-1:0] pins_f;

   assign pins_raw = {thermal_cooled, thermal_hot, overcurrent_detect, input_undervoltage_lockout_above_rise,
                      input_undervoltage_lockout_above_fall, enable_pin, voltage_select_bits};

   for (genvar i = 0; i < `BREGSQ_NPINS; i++) begin : g_sync
      logic s1_ff;
      logic s2_ff;
      logic s3_ff;
      logic filt_ff;
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            s1_ff   <= 1'b0;
            s2_ff   <= 1'b0;
            s3_ff   <= 1'b0;
            filt_ff <= 1'b0;
         end else begin
            s1_ff   <= pins_raw[i];
            s2_ff   <= s1_ff;
            s3_ff   <= s2_ff;
            filt_ff <= (s2_ff == s3_ff) ? s3_ff : filt_ff;
         end
      end
      assign pins_f[i] = filt_ff;
   end

   wire [2:0] vsel     = pins_f[2:0];
   wire       en_f     = pins_f[3];
   wire       ufall_f  = pins_f[4];
   wire       urise_f  = pins_f[5];
   wire       oc_f     = pins_f[6];
   wire       hot_f    = pins_f[7];
   wire       cool_f   = pins_f[8];

   // Registers and state
   bregsq_state_t state_ff;
   bregsq_state_t nxt_state;
   logic          input_undervoltage_lockout_lock_ff;
   logic          fb_mode_ff;
   bregsq_mv_t    target_ff;
   logic [15:0]   hold_cnt_ff;
   logic [15:0]   hiccup_cnt_ff;
   logic          sw_en_ff;
   logic          fb_select_ff;
   logic          high_side_en_ff;
   logic          low_side_force_ff;
   logic          switching_en_ff;
   logic          shutdown_ff;

   bregsq_ramp_if rif ();

   bregsq_ramp u_ramp (
      .aclk    (aclk),
      .aresetn (aresetn),
      .rif     (rif)
   );

   // Select decode
   wire        sel_ext    = (vsel == `BREGSQ_VSEL_EXT);
   wire [11:0] preset_mv  = (vsel == 3'h0) ? `BREGSQ_MV_SEL0 :
                            (vsel == 3'h1) ? `BREGSQ_MV_SEL1 :
                            (vsel == 3'h2) ? `BREGSQ_MV_SEL2 :
                            (vsel == 3'h3) ? `BREGSQ_MV_SEL3 :
                            (vsel == 3'h4) ? `BREGSQ_MV_SEL4 :
                            (vsel == 3'h5) ? `BREGSQ_MV_SEL5 :
                                             `BREGSQ_MV_SEL6;
   wire        active     = (state_ff == ST_SOFT) || (state_ff == ST_RUN);
   wire        run_ok     = en_f & sw_en_ff & ~input_undervoltage_lockout_lock_ff;
   wire        hold_done  = (hold_cnt_ff == 16'(OCP_HOLD_CYC - 1));
   wire        ocp_enter  = active & oc_f & (nxt_state == ST_OCP);
   // Mode is frozen while active; preset target tracks the pins, 111 is not followed
   wire        nxt_fbmode = active ? fb_mode_ff : sel_ext;
   wire [11:0] nxt_target = nxt_fbmode ? `BREGSQ_MV_FB :
                            (sel_ext ? target_ff : preset_mv);

   assign rif.hold_zero = ~active;
   assign rif.step_en   = active;
   assign rif.fb_mode   = fb_mode_ff;
   assign rif.target    = target_ff;

   always_comb begin
      nxt_state = state_ff;
      if (!run_ok) begin
         nxt_state = ST_OFF;
      end else begin
         unique case (state_ff)
            ST_OFF: begin
               nxt_state = hot_f ? ST_THERM : ST_SOFT;
            end
            ST_SOFT: begin
               if (hot_f) begin
                  nxt_state = ST_THERM;
               end else if (oc_f) begin
                  nxt_state = ST_OCP;
               end else if (rif.at_target) begin
                  nxt_state = ST_RUN;
               end
            end
            ST_RUN: begin
               if (hot_f) begin
                  nxt_state = ST_THERM;
               end else if (oc_f) begin
                  nxt_state = ST_OCP;
               end
            end
            ST_OCP: begin
               if (hot_f) begin
                  nxt_state = ST_THERM;
               end else if (hold_done) begin
                  nxt_state = ST_SOFT;
               end
            end
            ST_THERM: begin
               if (cool_f && !hot_f) begin
                  nxt_state = ST_SOFT;
               end
            end
            default: nxt_state = ST_OFF;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_ff     <= ST_OFF;
         input_undervoltage_lockout_lock_ff <= 1'b1;
         fb_mode_ff   <= 1'b0;
         target_ff    <= 12'h000;
         hold_cnt_ff  <= 16'h0000;
      end else begin
         state_ff     <= nxt_state;
         // Two thresholds give the lockout its hysteresis
         input_undervoltage_lockout_lock_ff <= !ufall_f ? 1'b1 : (urise_f ? 1'b0 : input_undervoltage_lockout_lock_ff);
         fb_mode_ff   <= nxt_fbmode;
         target_ff    <= nxt_target;
         hold_cnt_ff  <= (state_ff == ST_OCP) ? 16'(hold_cnt_ff + 16'h0001) : 16'h0000;
      end
   end

   // Power stage outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fb_select_ff      <= 1'b0;
         high_side_en_ff   <= 1'b0;
         low_side_force_ff <= 1'b0;
         switching_en_ff   <= 1'b0;
         shutdown_ff       <= 1'b1;
      end else begin
         fb_select_ff      <= nxt_fbmode;
         high_side_en_ff   <= (nxt_state == ST_SOFT) || (nxt_state == ST_RUN);
         low_side_force_ff <= (nxt_state == ST_OCP);
         switching_en_ff   <= (nxt_state == ST_SOFT) || (nxt_state == ST_RUN);
         shutdown_ff       <= (nxt_state == ST_OFF);
      end
   end

   assign ref_mv             = rif.ref_mv;
   assign fb_select          = fb_select_ff;
   assign high_side_en       = high_side_en_ff;
   assign low_side_force     = low_side_force_ff;
   assign switching_en       = switching_en_ff;
   assign shutdown_low_power = shutdown_ff;

   // AXI4-Lite slave
   logic                      awready_ff;
   logic                      wready_ff;
   logic                      aw_hold_ff;
   logic                      w_hold_ff;
   logic [`BREGSQ_ADDR_W-1:0] aw_addr_ff;
   logic [31:0]               w_data_ff;
   logic [3:0]                w_strb_ff;
   logic                      bvalid_ff;
   logic [1:0]                bresp_ff;
   logic                      arready_ff;
   logic                      rvalid_ff;
   logic [31:0]               rdata_ff;
   logic [1:0]                rresp_ff;

   wire aw_take  = s_axi_awvalid & awready_ff;
   wire w_take   = s_axi_wvalid & wready_ff;
   wire do_write = aw_hold_ff & w_hold_ff & ~bvalid_ff;
   wire b_done   = bvalid_ff & s_axi_bready;
   wire ar_take  = s_axi_arvalid & arready_ff;
   wire r_done   = rvalid_ff & s_axi_rready;
   wire wr_ctrl  = do_write & (aw_addr_ff == `BREGSQ_OFF_CTRL) & w_strb_ff[0];
   wire wr_hit   = (aw_addr_ff == `BREGSQ_OFF_CTRL) || (aw_addr_ff == `BREGSQ_OFF_STATUS) ||
                   (aw_addr_ff == `BREGSQ_OFF_REF)  || (aw_addr_ff == `BREGSQ_OFF_HICCUP);
   wire rd_hit   = (s_axi_araddr == `BREGSQ_OFF_CTRL) || (s_axi_araddr == `BREGSQ_OFF_STATUS) ||
                   (s_axi_araddr == `BREGSQ_OFF_REF)  || (s_axi_araddr == `BREGSQ_OFF_HICCUP);
   wire hic_clr  = wr_ctrl & w_data_ff[`BREGSQ_CTRL_CLR_BIT];

   wire [31:0] status_word = (32'(state_ff) << `BREGSQ_ST_STATE_LSB)
                           | (32'(fb_mode_ff)   << `BREGSQ_ST_FBMODE_BIT)
                           | (32'(input_undervoltage_lockout_lock_ff) << `BREGSQ_ST_INPUT_UNDERVOLTAGE_LOCKOUT_BIT)
                           | (32'(hot_f)        << `BREGSQ_ST_HOT_BIT)
                           | (32'(oc_f)         << `BREGSQ_ST_OC_BIT)
                           | (32'(en_f)         << `BREGSQ_ST_EN_BIT);
   wire [31:0] ref_word    = (32'(rif.ref_mv) << `BREGSQ_REF_CUR_LSB)
                           | (32'(target_ff)  << `BREGSQ_REF_TGT_LSB);
   wire [31:0] rd_mux      = (s_axi_araddr == `BREGSQ_OFF_CTRL)   ? 32'(sw_en_ff) :
                             (s_axi_araddr == `BREGSQ_OFF_STATUS) ? status_word :
                             (s_axi_araddr == `BREGSQ_OFF_REF)    ? ref_word :
                             (s_axi_araddr == `BREGSQ_OFF_HICCUP) ? 32'(hiccup_cnt_ff) :
                                                                    32'h0000_0000;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_ff <= 1'b1;
         wready_ff  <= 1'b1;
         aw_hold_ff <= 1'b0;
         w_hold_ff  <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= `BREGSQ_RESP_OKAY;
      end else begin
         awready_ff <= aw_take ? 1'b0 : (b_done ? 1'b1 : awready_ff);
         wready_ff  <= w_take ? 1'b0 : (b_done ? 1'b1 : wready_ff);
         aw_hold_ff <= aw_take ? 1'b1 : (do_write ? 1'b0 : aw_hold_ff);
         w_hold_ff  <= w_take ? 1'b1 : (do_write ? 1'b0 : w_hold_ff);
         aw_addr_ff <= aw_take ? s_axi_awaddr : aw_addr_ff;
         w_data_ff  <= w_take ? s_axi_wdata : w_data_ff;
         w_strb_ff  <= w_take ? s_axi_wstrb : w_strb_ff;
         bvalid_ff  <= do_write ? 1'b1 : (b_done ? 1'b0 : bvalid_ff);
         bresp_ff   <= do_write ? (wr_hit ? `BREGSQ_RESP_OKAY : `BREGSQ_RESP_SLVERR) : bresp_ff;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_ff <= 1'b1;
         rvalid_ff  <= 1'b0;
         rdata_ff   <= 32'h0000_0000;
         rresp_ff   <= `BREGSQ_RESP_OKAY;
      end else begin
         arready_ff <= ar_take ? 1'b0 : (r_done ? 1'b1 : arready_ff);
         rvalid_ff  <= ar_take ? 1'b1 : (r_done ? 1'b0 : rvalid_ff);
         rdata_ff   <= ar_take ? rd_mux : rdata_ff;
         rresp_ff   <= ar_take ? (rd_hit ? `BREGSQ_RESP_OKAY : `BREGSQ_RESP_SLVERR) : rresp_ff;
      end
   end

   // Software enable and hiccup counter; a new event in the same cycle as a clear restarts the count at one
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sw_en_ff      <= `BREGSQ_CTRL_SWEN_RST;
         hiccup_cnt_ff <= 16'h0000;
      end else begin
         sw_en_ff      <= wr_ctrl ? w_data_ff[`BREGSQ_CTRL_SWEN_BIT] : sw_en_ff;
         if (ocp_enter) begin
            hiccup_cnt_ff <= (hic_clr ? 16'h0000 : hiccup_cnt_ff)
                             + ((hiccup_cnt_ff == 16'hFFFF && !hic_clr) ? 16'h0000 : 16'h0001);
         end else if (hic_clr) begin
            hiccup_cnt_ff <= 16'h0000;
         end
      end
   end

   assign s_axi_awready = awready_ff;
   assign s_axi_wready  = wready_ff;
   assign s_axi_bvalid  = bvalid_ff;
   assign s_axi_bresp   = bresp_ff;
   assign s_axi_arready = arready_ff;
   assign s_axi_rvalid  = rvalid_ff;
   assign s_axi_rdata   = rdata_ff;
   assign s_axi_rresp   = rresp_ff;

endmodule

/* verification/bregsq_top_properties.sv */
`timescale 1ns/1ps
module bregsq_top_properties #(
   parameter int unsigned OCP_HOLD_CYC = 40000
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Pins and comparators
   input wire logic        enable_pin,
   input wire logic        input_undervoltage_lockout_above_fall,
   input wire logic        thermal_hot,
   // Power stage
   input wire logic [11:0] ref_mv,
   input wire logic        fb_select,
   input wire logic        high_side_en,
   input wire logic        low_side_force,
   input wire logic        switching_en,
   input wire logic        shutdown_low_power,
   // Write response
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic [1:0]  s_axi_bresp
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [31:0] hold_cnt_ff;
   logic [15:0] gap_cnt_ff;
   // Hold length and cycles since the last reference step
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         hold_cnt_ff <= 32'h0;
         gap_cnt_ff  <= 16'h0;
      end else begin
         hold_cnt_ff <= low_side_force ? hold_cnt_ff + 32'h1 : 32'h0;
         gap_cnt_ff  <= $changed(ref_mv) ? 16'h0 : gap_cnt_ff + {15'h0, gap_cnt_ff != 16'hFFFF};
      end
   end
   sequence ocp_leave_s;
      $fell(low_side_force) && switching_en;
   endsequence
   off_outputs_a: assert property (shutdown_low_power |-> !switching_en && !high_side_en)
      else $error("power stage active while shut down");
   ocp_drive_a: assert property (low_side_force |-> !high_side_en && !switching_en)
      else $error("high side on during overcurrent hold");
   ocp_hold_a: assert property (ocp_leave_s |-> hold_cnt_ff == OCP_HOLD_CYC)
      else $error("overcurrent hold has wrong length");
   ocp_restart_a: assert property (ocp_leave_s |-> ref_mv == 12'h000)
      else $error("restart after hold not from zero");
   ref_step_a: assert property ($changed(ref_mv) && switching_en && $past(switching_en) |->
      ref_mv == $past(ref_mv) + 12'h001 || ref_mv == $past(ref_mv) - 12'h001)
      else $error("reference jumped");
   slew_gap_a: assert property ($changed(ref_mv) && switching_en |->
      gap_cnt_ff >= (fb_select ? 16'h0047 : 16'h0017))
      else $error("reference stepped too fast");
   input_undervoltage_lockout_off_a: assert property (!input_undervoltage_lockout_above_fall [*8] |-> !switching_en)
      else $error("switching under input lockout");
   enable_off_a: assert property (!enable_pin [*8] |-> shutdown_low_power)
      else $error("not shut down with enable low");
   hot_off_a: assert property (thermal_hot [*8] |-> !switching_en)
      else $error("switching while overheated");
   fb_ref_a: assert property (fb_select && switching_en |-> ref_mv <= 12'h25B)
      else $error("feedback reference above its value");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped early");
endmodule
bind bregsq_top bregsq_top_properties #(.OCP_HOLD_CYC(OCP_HOLD_CYC)) i_props (.*);

/* verification/bregsq_host_model.sv */
`timescale 1ns/1ps
module bregsq_host_model (
   // Clock
   input  wire logic       aclk,
   // Requests from the bench
   input  wire logic       supply_ok,
   input  wire logic       want_en,
   input  wire logic [2:0] want_sel,
   // Regulator pins
   output logic [2:0]      voltage_select_bits,
   output logic            enable_pin
);
   wire logic mode_same = (want_sel == 3'h7) == (voltage_select_bits == 3'h7);
   initial begin
      voltage_select_bits = 3'h0;
      enable_pin = 1'b0;
   end
   always @(posedge aclk) begin
      enable_pin <= want_en & supply_ok;
      // Mode swaps only while held off
      if (!enable_pin || mode_same) begin
         voltage_select_bits <= want_sel;
      end
   end
endmodule

/* verification/test_buck_regulator_sequencer.sv */
`timescale 1ns/1ps
`include "bregsq_consts.svh"
module test_buck_regulator_sequencer;
   localparam int PER = `BREGSQ_SLEW_CYC;
   localparam int FB_PER = `BREGSQ_FB_STEP_CYC;
   localparam logic [11:0] TAB [7] = '{12'hCE4, 12'h9C4, 12'h708, 12'h5DC, 12'h4E2, 12'h4B0,
                                       12'h320};
   logic        aclk = 1'b0, aresetn = 1'b0, supply_ok = 1'b0, want_en = 1'b0;
   logic [2:0]  want_sel = 3'h6, voltage_select_bits;
   logic        enable_pin, input_undervoltage_lockout_above_rise = 1'b0, input_undervoltage_lockout_above_fall = 1'b0;
   logic        overcurrent_detect = 1'b0, thermal_hot = 1'b0, thermal_cooled = 1'b0;
   logic [11:0] ref_mv;
   logic        fb_select, high_side_en, low_side_force, switching_en, shutdown_low_power;
   logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   int          err_count = 0, samples_checked = 0;

   always #12.5 aclk = ~aclk;

   bregsq_host_model i_host (.*);
   bregsq_top #(.OCP_HOLD_CYC(50)) i_dut (.*);

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw, w;
      aw = 1'b1;
      w = 1'b1;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) aw = 1'b0;
         if (s_axi_wready === 1'b1) w = 1'b0;
         s_axi_awvalid <= aw;
         s_axi_wvalid <= w;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      chk(s_axi_bresp, er);
   endtask
   task automatic axi_rd(input logic [3:0] a, input logic [1:0] er);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      chk(s_axi_rresp, er);
   endtask
   function automatic logic sig(input int k);
      case (k)
         0: return switching_en;
         1: return low_side_force;
         default: return shutdown_low_power;
      endcase
   endfunction
   task automatic wait_sig(input int k, input logic v, input int lim);
      int n;
      n = 0;
      while (sig(k) !== v && n < lim) begin
         @(posedge aclk);
         n++;
      end
      chk(sig(k), v);
   endtask
   // Time a ramp from the present reference to the target
   task automatic ramp(input logic [11:0] tgt, input int per);
      int n, d;
      n = 0;
      d = (tgt > ref_mv) ? tgt - ref_mv : ref_mv - tgt;
      while (ref_mv !== tgt && n < (d + 4) * per) begin
         @(posedge aclk);
         n++;
      end
      chk(ref_mv, tgt);
      chk(n > (d - 2) * per && n < (d + 2) * per, 1'b1);
   endtask
   task automatic tally_and_finish;
      if (err_count == 0 && samples_checked > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge aclk);
      err_count++;
      tally_and_finish;
   end

   initial begin
      tick(2);
      aresetn <= 1'b1;
      axi_rd(4'h0, 2'h0);
      chk(rd, 32'h1);
      axi_rd(4'h2, 2'h2);
      chk(rd, 32'h0);
      // Unmapped write is refused and leaves control alone
      axi_wr(4'h2, 32'h0, 2'h2);
      axi_rd(4'h0, 2'h0);
      chk(rd, 32'h1);
      supply_ok <= 1'b1;
      want_en <= 1'b1;
      tick(20);
      chk(switching_en, 1'b0);
      input_undervoltage_lockout_above_rise <= 1'b1;
      input_undervoltage_lockout_above_fall <= 1'b1;
      wait_sig(0, 1'b1, 12);
      ramp(12'h320, PER);
      for (int k = 0; k < 7; k++) begin
         want_sel <= 3'(k);
         tick(8);
         axi_rd(4'h8, 2'h0);
         chk(rd[27:16], TAB[k]);
      end
      chk(switching_en, 1'b1);
      chk(fb_select, 1'b0);
      want_sel <= 3'h5;
      ramp(12'h4B0, PER);
      overcurrent_detect <= 1'b1;
      wait_sig(1, 1'b1, 12);
      chk(high_side_en, 1'b0);
      overcurrent_detect <= 1'b0;
      wait_sig(0, 1'b1, 70);
      chk(ref_mv < 12'h002, 1'b1);
      overcurrent_detect <= 1'b1;
      wait_sig(1, 1'b1, 12);
      wait_sig(1, 1'b0, 70);
      wait_sig(1, 1'b1, 12);
      overcurrent_detect <= 1'b0;
      wait_sig(1, 1'b0, 70);
      axi_rd(4'hC, 2'h0);
      chk(rd[15:0], 16'h0003);
      axi_wr(4'h0, 32'h3, 2'h0);
      axi_rd(4'hC, 2'h0);
      chk(rd[15:0], 16'h0000);
      thermal_hot <= 1'b1;
      wait_sig(0, 1'b0, 12);
      axi_rd(4'h4, 2'h0);
      chk(rd[4:0], 5'h10);
      tick(8);
      thermal_hot <= 1'b0;
      tick(20);
      chk(switching_en, 1'b0);
      thermal_cooled <= 1'b1;
      wait_sig(0, 1'b1, 12);
      input_undervoltage_lockout_above_fall <= 1'b0;
      input_undervoltage_lockout_above_rise <= 1'b0;
      wait_sig(0, 1'b0, 12);
      tick(8);
      input_undervoltage_lockout_above_fall <= 1'b1;
      tick(20);
      chk(switching_en, 1'b0);
      input_undervoltage_lockout_above_rise <= 1'b1;
      wait_sig(0, 1'b1, 12);
      // Software enable off and back on
      axi_wr(4'h0, 32'h0, 2'h0);
      wait_sig(2, 1'b1, 12);
      axi_wr(4'h0, 32'h1, 2'h0);
      wait_sig(0, 1'b1, 12);
      want_en <= 1'b0;
      wait_sig(2, 1'b1, 12);
      chk(switching_en, 1'b0);
      want_sel <= 3'h7;
      tick(10);
      want_en <= 1'b1;
      wait_sig(0, 1'b1, 12);
      chk(fb_select, 1'b1);
      ramp(12'h25B, FB_PER);
      tally_and_finish;
   end
endmodule
